//--- rmc_cfg.svh
// Purpose: constants of the radio mode controller
// Assumes: 20 MHz clk_i
// Notes:   offsets are byte addresses on the AHB-Lite slave
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

`define RMC_CLK_MHZ          20
// ----------------------------------------------------------------
// timing in ns and cycles
// ----------------------------------------------------------------
`define RMC_SETTLE_NS        130000
`define RMC_SETTLE_CYC       ((`RMC_SETTLE_NS * `RMC_CLK_MHZ) / 1000)
`define RMC_MIN_CE_NS        10000
`define RMC_MIN_CE_CYC       ((`RMC_MIN_CE_NS * `RMC_CLK_MHZ + 999) / 1000)
`define RMC_CS_NS            128000
`define RMC_CS_CYC           ((`RMC_CS_NS * `RMC_CLK_MHZ + 999) / 1000)
`define RMC_TX_LIMIT_NS      4000000
`define RMC_TX_LIMIT_CYC     ((`RMC_TX_LIMIT_NS * `RMC_CLK_MHZ) / 1000)
`define RMC_PKT_CYC_DEF      2000
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RMC_OFF_CONFIG       8'h00
`define RMC_OFF_SETUP        8'h04
`define RMC_OFF_CHANNEL      8'h08
`define RMC_OFF_STATUS       8'h0c
`define RMC_OFF_FREQ         8'h10
`define RMC_BIT_POWER_ON     0
`define RMC_BIT_RX_SEL       1
`define RMC_BIT_AIR_RATE     3
`define RMC_LSB_TX_PWR       1
`define RMC_RST_SETUP        8'h07
`define RMC_RST_CHANNEL      7'h02
`define RMC_BASE_MHZ         12'h960
`endif

//--- rmc_pkg.sv
// Purpose: types of the radio mode controller
// Assumes: nothing
// Notes:   none
package rmc_pkg;
	typedef enum logic [2:0] {
		RMC_POWER_DOWN,
		RMC_STANDBY_1,
		RMC_STANDBY_2,
		RMC_SETTLE,
		RMC_RX,
		RMC_TX
	} rmc_mode_t;
endpackage

//--- rmc_timer.sv
// Purpose: loadable down counter with done flag
// Assumes: one clock
// Notes:   done stays high while count is zero
`timescale 1ns/10ps
module rmc_timer (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        load_i,
	input  wire logic [22:0] value_i,
	input  wire logic        run_i,
	output logic             done_o
);
	logic [22:0] count;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= 23'h0;
		end else if (load_i) begin
			count <= value_i;
		end else if (run_i && count != 23'h0) begin
			count <= count - 23'h1;
		end
	end

	assign done_o = (count == 23'h0);
endmodule

//--- rmc_core.sv
// Purpose: operating-mode controller of a 2.4 GHz packet radio
// Assumes: AHB-Lite slave, 20 MHz clock, pins synchronised here
// Notes:   packet air time is a stand-in count, tx_fifo_empty from logic
// Function
// - clearing power_on_bit forces power down, registers and bus stay alive
// - setting power_on_bit moves power down to standby-I
// - activate pin low in TX or RX returns to standby-I
// - sender with activate high and empty FIFO waits in standby-II
// - receive needs power_on, receive_select and activate all high
// - accept packet only on address and CRC match, drop when FIFO full
// - receive persists until host selects standby-I, clears receive_select (settle to TX) or selects power down
// - carrier_sense after 128 us of in-channel signal, low outside RX
// - transmit from standby-I needs power_on, not receive_select, payload, activate over 10 us
// - finish packet, then standby-I, next packet, or standby-II
// - activate held high drains the FIFO, restart when select rises
// - short activate pulse sends exactly one packet then standby-I
// - standby to TX or RX, and TX to RX, settle 130 us
// - air rate bit selects 1 or 2 Mbps
// - channel centre is 2400 MHz plus channel_index
// - tx_power_level selects output power in four steps
// - after power-on reset the block sits in power down
`timescale 1ns/10ps
`include "rmc_cfg.svh"
module rmc_core #(
	parameter int PKT_CYC = `RMC_PKT_CYC_DEF
) (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic               hsel_i,
	input  wire logic               hready_i,
	input  wire logic [31:0]        hwdata_i,
	output logic [31:0]             hrdata_o,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	input  wire logic               activate_i,
	input  wire logic               serial_select_i,
	input  wire logic               rf_signal_i,
	input  wire logic               tx_fifo_empty_i,
	input  wire logic               rx_fifo_full_i,
	input  wire logic               rx_pkt_valid_i,
	output logic                    rx_pkt_store_o,
	output logic                    tx_pkt_done_o,
	output rmc_pkg::rmc_mode_t      mode_o,
	output logic                    carrier_sense_o,
	output logic                    air_rate_select_o,
	output logic [11:0]             freq_mhz_o,
	output logic [1:0]              tx_power_level_o
);
	import rmc_pkg::*;

	// timer runs down to zero and the mode moves one edge later, so load one less
	localparam logic [22:0] SETTLE_LOAD = 23'(`RMC_SETTLE_CYC - 1);
	localparam logic [22:0] MIN_CE_CYC = 23'(`RMC_MIN_CE_CYC);
	localparam logic [22:0] CS_CYC     = 23'(`RMC_CS_CYC);
	localparam logic [22:0] PKT_LEN    = 23'(PKT_CYC);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] act_sync;
	logic [1:0] sel_sync;
	logic [1:0] rf_sync;
	logic       act;
	logic       sel;
	logic       sel_prev;
	logic       rf;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			act_sync <= 2'h0;
			sel_sync <= 2'h3;
			rf_sync  <= 2'h0;
			sel_prev <= 1'b1;
		end else begin
			act_sync <= {act_sync[0], activate_i};
			sel_sync <= {sel_sync[0], serial_select_i};
			rf_sync  <= {rf_sync[0], rf_signal_i};
			sel_prev <= sel_sync[1];
		end
	end

	assign act = act_sync[1];
	assign sel = sel_sync[1];
	assign rf  = rf_sync[1];

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	logic        power_on_bit;
	logic        receive_select_bit;
	logic [7:0]  radio_setup_reg;
	logic [6:0]  channel_index;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        carrier_sense;
	rmc_mode_t   mode;

	function automatic logic [11:0] freq_of(input logic [6:0] ch);
		freq_of = `RMC_BASE_MHZ + {5'h0, ch};
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		case (a)
			`RMC_OFF_CONFIG:  read_mux = {30'h0, receive_select_bit, power_on_bit};
			`RMC_OFF_SETUP:   read_mux = {24'h0, radio_setup_reg};
			`RMC_OFF_CHANNEL: read_mux = {25'h0, channel_index};
			`RMC_OFF_STATUS:  read_mux = {28'h0, carrier_sense, mode};
			`RMC_OFF_FREQ:    read_mux = {20'h0, freq_of(channel_index)};
			default:          read_mux = 32'h0;
		endcase
	endfunction

	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_pend  <= 1'b0;
			wr_addr  <= 8'h0;
			hrdata_o <= 32'h0;
		end else if (hready_i) begin
			wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
			wr_addr <= haddr_i[7:0];
			if (hsel_i && htrans_i[1] && !hwrite_i) begin
				hrdata_o <= read_mux(haddr_i[7:0]);
			end
		end
	end

	// register contents survive every mode, power down included
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			power_on_bit       <= 1'b0;
			receive_select_bit <= 1'b0;
			radio_setup_reg    <= `RMC_RST_SETUP;
			channel_index      <= `RMC_RST_CHANNEL;
		end else if (wr_pend) begin
			case (wr_addr)
				`RMC_OFF_CONFIG: begin
					power_on_bit       <= hwdata_i[`RMC_BIT_POWER_ON];
					receive_select_bit <= hwdata_i[`RMC_BIT_RX_SEL];
				end
				`RMC_OFF_SETUP:   radio_setup_reg <= hwdata_i[7:0];
				`RMC_OFF_CHANNEL: channel_index   <= hwdata_i[6:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// radio settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			air_rate_select_o <= 1'b0;
			tx_power_level_o  <= 2'h0;
			freq_mhz_o        <= 12'h0;
		end else begin
			air_rate_select_o <= radio_setup_reg[`RMC_BIT_AIR_RATE];
			tx_power_level_o  <= radio_setup_reg[`RMC_LSB_TX_PWR +: 2];
			freq_mhz_o        <= freq_of(channel_index);
		end
	end

	// ----------------------------------------------------------------
	// activate pulse width and single-shot latch
	// ----------------------------------------------------------------
	logic [22:0] ce_cnt;
	logic        ce_long;
	logic        ce_armed;

	assign ce_long = (ce_cnt > MIN_CE_CYC);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ce_cnt <= 23'h0;
		end else if (!act || !power_on_bit) begin
			ce_cnt <= 23'h0;
		end else if (!ce_long) begin
			ce_cnt <= ce_cnt + 23'h1;
		end
	end

	// a qualified pulse stays remembered in standby-I and settling until a packet leaves
	logic tx_start;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ce_armed <= 1'b0;
		end else if (!power_on_bit) begin
			ce_armed <= 1'b0;
		end else if (ce_long && act) begin
			ce_armed <= 1'b1;
		end else if (tx_start || (mode != RMC_STANDBY_1 && mode != RMC_SETTLE)) begin
			// a level held through RX, TX or standby-II must not arm a later upload
			ce_armed <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// mode machine
	// ----------------------------------------------------------------
	logic        tmr_load;
	logic [22:0] tmr_value;
	logic        tmr_done;
	rmc_mode_t   next_mode;
	logic        settle_to_rx;
	logic        next_settle_to_rx;
	logic        want_tx;

	rmc_timer u_timer (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (tmr_load),
		.value_i   (tmr_value),
		.run_i     (1'b1),
		.done_o    (tmr_done)
	);

	// uploads finish when the serial select rises again
	assign want_tx  = !tx_fifo_empty_i && sel && sel_prev;
	assign tx_start = (mode == RMC_SETTLE) && tmr_done && !settle_to_rx;

	always_comb begin
		next_mode         = mode;
		next_settle_to_rx = settle_to_rx;
		tmr_load          = 1'b0;
		tmr_value         = SETTLE_LOAD;
		if (!power_on_bit) begin
			next_mode = RMC_POWER_DOWN;
		end else begin
			case (mode)
				RMC_POWER_DOWN: next_mode = RMC_STANDBY_1;
				RMC_STANDBY_1: begin
					if (act && receive_select_bit) begin
						next_mode         = RMC_SETTLE;
						next_settle_to_rx = 1'b1;
						tmr_load          = 1'b1;
					end else if (!receive_select_bit && ce_armed && want_tx) begin
						next_mode         = RMC_SETTLE;
						next_settle_to_rx = 1'b0;
						tmr_load          = 1'b1;
					end else if (act && !receive_select_bit && tx_fifo_empty_i) begin
						next_mode = RMC_STANDBY_2;
					end
				end
				RMC_STANDBY_2: begin
					if (!act || receive_select_bit) begin
						next_mode = RMC_STANDBY_1;
					end else if (!tx_fifo_empty_i && sel) begin
						next_mode         = RMC_SETTLE;
						next_settle_to_rx = 1'b0;
						tmr_load          = 1'b1;
					end
				end
				RMC_SETTLE: begin
					if (!act && settle_to_rx) begin
						next_mode = RMC_STANDBY_1;
					end else if (tmr_done) begin
						next_mode = settle_to_rx ? RMC_RX : RMC_TX;
						tmr_load  = !settle_to_rx;
						tmr_value = PKT_LEN;
					end
				end
				RMC_RX: begin
					if (!act) begin
						next_mode = RMC_STANDBY_1;
					end else if (!receive_select_bit) begin
						next_mode         = RMC_SETTLE;
						next_settle_to_rx = 1'b0;
						tmr_load          = 1'b1;
					end
				end
				RMC_TX: begin
					if (tmr_done) begin
						if (receive_select_bit && act) begin
							next_mode         = RMC_SETTLE;
							next_settle_to_rx = 1'b1;
							tmr_load          = 1'b1;
						end else if (!act) begin
							next_mode = RMC_STANDBY_1;
						end else if (!tx_fifo_empty_i) begin
							tmr_load  = 1'b1;
							tmr_value = PKT_LEN;
						end else begin
							next_mode = RMC_STANDBY_2;
						end
					end
				end
				default: next_mode = RMC_POWER_DOWN;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode         <= RMC_POWER_DOWN;
			settle_to_rx <= 1'b0;
		end else begin
			mode         <= next_mode;
			settle_to_rx <= next_settle_to_rx;
		end
	end

	assign mode_o        = mode;
	assign tx_pkt_done_o = (mode == RMC_TX) && tmr_done;

	// ----------------------------------------------------------------
	// receive path and carrier sense
	// ----------------------------------------------------------------
	assign rx_pkt_store_o = (mode == RMC_RX) && rx_pkt_valid_i && !rx_fifo_full_i;

	logic [22:0] cs_cnt;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_cnt        <= 23'h0;
			carrier_sense <= 1'b0;
		end else if (mode != RMC_RX || !rf) begin
			cs_cnt        <= 23'h0;
			carrier_sense <= 1'b0;
		end else if (cs_cnt < CS_CYC) begin
			cs_cnt <= cs_cnt + 23'h1;
		end else begin
			carrier_sense <= 1'b1;
		end
	end

	assign carrier_sense_o = carrier_sense;
endmodule

//--- rmc_assertions.sv
// Purpose: port checker for rmc_core
// Assumes: bound in the bench
// Notes:   none
`timescale 1ns/10ps
`include "rmc_cfg.svh"
module rmc_assertions
	import rmc_pkg::*;
(
	input wire logic      clk_i,
	input wire logic      reset_n_i,
	input wire logic      rf_signal_i,
	input wire logic      rx_fifo_full_i,
	input wire logic      rx_pkt_valid_i,
	input wire logic      hreadyout_o,
	input wire logic      hresp_o,
	input wire logic      rx_pkt_store_o,
	input wire logic      tx_pkt_done_o,
	input rmc_mode_t      mode_o,
	input wire logic      carrier_sense_o
);
	int rf_cnt;
	int stl_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// raw count is a lower bound, sync adds two more cycles
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rf_cnt <= 0;
			stl_cnt <= 0;
		end else begin
			rf_cnt <= rf_signal_i ? rf_cnt + 1 : 0;
			stl_cnt <= (mode_o == RMC_SETTLE) ? stl_cnt + 1 : 0;
		end
	end
	sequence pd_left;
		mode_o == RMC_POWER_DOWN ##1 mode_o != RMC_POWER_DOWN;
	endsequence
	wake_step_a: assert property (pd_left |-> mode_o == RMC_STANDBY_1)
		else $error("power down left to a mode other than standby-I");
	rx_entry_a: assert property ($rose(mode_o == RMC_RX) |-> $past(mode_o) == RMC_SETTLE)
		else $error("receive entered without settling");
	tx_entry_a: assert property ($rose(mode_o == RMC_TX) |-> $past(mode_o) == RMC_SETTLE)
		else $error("transmit entered without settling");
	settle_bound_a: assert property (stl_cnt <= `RMC_SETTLE_CYC)
		else $error("settling too long");
	pkt_done_a: assert property (tx_pkt_done_o |-> mode_o == RMC_TX)
		else $error("packet done outside transmit");
	rx_store_a: assert property (rx_pkt_store_o |-> rx_pkt_valid_i && !rx_fifo_full_i
		&& mode_o == RMC_RX)
		else $error("packet stored wrongly");
	cs_mode_a: assert property (carrier_sense_o |-> $past(mode_o) == RMC_RX)
		else $error("carrier sense outside receive");
	cs_filter_a: assert property ($rose(carrier_sense_o) |-> rf_cnt >= `RMC_CS_CYC)
		else $error("carrier sense too early");
	bus_resp_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or error");
endmodule

//--- rmc_host_model.sv
// Purpose: host side: tx fifo level and upload select
// Assumes: one upload takes four cycles
// Notes:   serial select and fifo level registered to avoid races
`timescale 1ns/10ps
module rmc_host_model (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic upload_i,
	input  wire logic activate_i,
	input  wire logic tx_pkt_done_i,
	output logic      tx_fifo_empty_o,
	output logic      serial_select_o
);
	int   lvl;
	int   pend;
	int   sel;
	int   since;
	int   lvl_q;
	logic act_q;

	// the packet on air leaves the fifo as its air time ends
	assign tx_fifo_empty_o = (lvl_q - int'(tx_pkt_done_i)) <= 0;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lvl = 0;
			pend = 0;
			sel = 0;
			since = 1000;
			act_q = 0;
		end else begin
			since = (activate_i && !act_q) ? 0 : since + 1;
			act_q = activate_i;
			pend = pend + int'(upload_i);
			lvl = lvl - int'(tx_pkt_done_i);
			if (sel == 1)
				lvl = lvl + 1;
			if (sel > 0)
				sel = sel - 1;
			else if (pend > 0 && since >= 80) begin
				sel = 4;
				pend = pend - 1;
			end
		end
		lvl_q <= lvl;
		serial_select_o <= (sel == 0);
	end
endmodule

//--- rmc_core_tb.sv
// Purpose: self-checking bench of rmc_core
// Assumes: 20 MHz clock, short packet time
// Notes:   none
`timescale 1ns/10ps
`include "rmc_cfg.svh"
module rmc_core_tb;
	import rmc_pkg::*;
	localparam int PKT = 20;
	logic        clk_i = 0;
	logic        reset_n_i = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] rd, hrdata;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0, act = 0, rf = 0, full = 0, valid = 0, upl = 0;
	logic        rdy, resp, store, done, cs, rate, empty, sel;
	logic [11:0] freq;
	logic [1:0]  pwr;
	rmc_mode_t   mode;
	int          failures = 0, cmp_count = 0, ndone = 0, n, ch;
	logic [31:0] seed = 29214;
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (done === 1'b1) ndone <= ndone + 1;
	rmc_core #(.PKT_CYC(PKT)) rmc_core_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hsel_i(1'b1),
		.hready_i(rdy), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp),
		.activate_i(act), .serial_select_i(sel), .rf_signal_i(rf), .tx_fifo_empty_i(empty),
		.rx_fifo_full_i(full), .rx_pkt_valid_i(valid), .rx_pkt_store_o(store),
		.tx_pkt_done_o(done), .mode_o(mode), .carrier_sense_o(cs), .air_rate_select_o(rate),
		.freq_mhz_o(freq), .tx_power_level_o(pwr));
	rmc_host_model rmc_host_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .upload_i(upl),
		.activate_i(act), .tx_pkt_done_i(done), .tx_fifo_empty_o(empty), .serial_select_o(sel));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// entered just after a rising edge; holds each phase until ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do begin @(posedge clk_i); k++; end while (rdy !== 1'b1 && k < 50);
		if (rdy !== 1'b1) begin failures++; finish_test(); end
		htrans <= 2'b00;
		hwdata <= d;
		do begin @(posedge clk_i); k++; end while (rdy !== 1'b1 && k < 100);
		rd = hrdata;
		if (rdy !== 1'b1) begin failures++; finish_test(); end
	endtask
	task automatic wait_mode(input rmc_mode_t m, input int lim);
		int k;
		k = 0;
		while (mode !== m && k < lim) begin @(posedge clk_i); k++; end
		check(32'(mode), 32'(m));
		if (k >= lim) finish_test();
	endtask
	task automatic upload(input int cnt);
		upl <= 1'b1;
		repeat (cnt) @(posedge clk_i);
		upl <= 1'b0;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		failures++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check(32'(mode), 32'(RMC_POWER_DOWN));
		check(32'(freq), 32'h0000_0962);
		bus(0, `RMC_OFF_SETUP, 0);
		check(rd, 32'(`RMC_RST_SETUP));
		bus(0, 8'h20, 0);
		check(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1, `RMC_OFF_SETUP, 32'((i % 2) * 8 + i * 2));
			ch = int'(xs() % 126);
			bus(1, `RMC_OFF_CHANNEL, 32'(ch));
			bus(0, `RMC_OFF_FREQ, 0);
			check(rd, 32'(2400 + ch));
			check(32'(freq), 32'(2400 + ch));
			check(32'(pwr), 32'(i));
			check(32'(rate), 32'(i % 2));
		end
		$display("settings test done");
		bus(1, `RMC_OFF_CONFIG, 3);
		wait_mode(RMC_STANDBY_1, 4);
		act <= 1'b1;
		wait_mode(RMC_RX, 2650);
		rf <= 1'b1;
		n = 0;
		while (cs !== 1'b1 && n < 2700) begin @(posedge clk_i); n++; end
		check(32'(n >= 2560 && n < 2600), 1);
		check(32'(mode), 32'(RMC_RX));
		valid <= 1'b1;
		@(negedge clk_i) check(32'(store), 1);
		@(posedge clk_i) full <= 1'b1;
		@(negedge clk_i) check(32'(store), 0);
		@(posedge clk_i) valid <= 1'b0;
		full <= 1'b0;
		rf <= 1'b0;
		act <= 1'b0;
		wait_mode(RMC_STANDBY_1, 6);
		check(32'(cs), 0);
		act <= 1'b1;
		bus(1, `RMC_OFF_CONFIG, 2);
		wait_mode(RMC_POWER_DOWN, 4);
		repeat (2700) @(posedge clk_i);
		check(32'(mode), 32'(RMC_POWER_DOWN));
		bus(0, `RMC_OFF_CHANNEL, 0);
		check(rd, 32'(ch));
		$display("receive and power down test done");
		act <= 1'b0;
		bus(1, `RMC_OFF_CONFIG, 1);
		repeat (30000) @(posedge clk_i);
		upload(1);
		repeat (10) @(posedge clk_i);
		check(32'(empty), 0);
		check(32'(mode), 32'(RMC_STANDBY_1));
		act <= 1'b1;
		repeat (220) @(posedge clk_i);
		act <= 1'b0;
		wait_mode(RMC_TX, 2700);
		wait_mode(RMC_STANDBY_1, PKT + 10);
		check(32'(ndone), 1);
		act <= 1'b1;
		upload(2);
		wait_mode(RMC_TX, 2800);
		wait_mode(RMC_STANDBY_2, 2 * PKT + 20);
		check(32'(ndone), 3);
		upload(1);
		wait_mode(RMC_TX, 2700);
		wait_mode(RMC_STANDBY_2, PKT + 20);
		check(32'(ndone), 4);
		act <= 1'b0;
		wait_mode(RMC_STANDBY_1, 6);
		upload(1);
		repeat (20) @(posedge clk_i);
		check(32'(mode), 32'(RMC_STANDBY_1));
		$display("transmit test done");
		bus(1, `RMC_OFF_CONFIG, 3);
		act <= 1'b1;
		wait_mode(RMC_RX, 2650);
		bus(1, `RMC_OFF_CONFIG, 1);
		wait_mode(RMC_TX, 2700);
		act <= 1'b0;
		wait_mode(RMC_STANDBY_1, PKT + 10);
		check(32'(ndone), 5);
		$display("switch test done");
		finish_test();
	end
endmodule
bind rmc_core rmc_assertions rmc_assertions_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.rf_signal_i(rf_signal_i), .rx_fifo_full_i(rx_fifo_full_i), .rx_pkt_valid_i(rx_pkt_valid_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_pkt_store_o(rx_pkt_store_o),
	.tx_pkt_done_o(tx_pkt_done_o), .mode_o(mode_o), .carrier_sense_o(carrier_sense_o));
